// ===== src/fault_status_pkg.sv
// Constants, field positions and carrier types of the fault status bank.
// Assumes one 100 MHz clock and a command decoder in front of the bank.
//
// Summary of operation
// - Word low byte is the summary byte
// - Byte bit 6 set while output unpowered
// - Byte bit 5 on output overvoltage fault
// - Byte bit 4 on output overcurrent fault
// - Byte bit 3 on input undervoltage fault
// - Byte bit 2 on temperature fault/warning
// - Byte bit 1 on communications/memory/logic fault
// - Word bit 15 on output voltage status
// - Word bit 14 on output current fault
// - Word bit 13 on input voltage status
// - Word bit 12 on manufacturer status
// - Word bit 11 while power not good
// - Power good may wait 2ms after enable
// - Word bit 9 when any detail bit set
// - Vout status bit 7 overvoltage fault
// - Vout status bit 6 overvoltage warning
// - Vout status bit 5 undervoltage warning
// - Vout status bit 4 undervoltage fault
// - Vout bit 3 on setpoint out of range
// - Fault may set without its warning
// - Status write flags invalid write in CML
package fault_status_pkg;

  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_SUMMARY_BYTE = 8'h78;
  localparam logic [7:0] CMD_SUMMARY_WORD = 8'h79;
  localparam logic [7:0] CMD_VOUT_STATUS  = 8'h7a;

  localparam logic [15:0] SUMMARY_RESET = 16'h0000;
  localparam logic [7:0]  DETAIL_RESET  = 8'h00;

  // ==========================================================
  // Summary word bit positions
  localparam int SW_VOUT  = 15;
  localparam int SW_IOUT  = 14;
  localparam int SW_INPUT = 13;
  localparam int SW_MFR   = 12;
  localparam int SW_PGN   = 11;
  localparam int SW_OTHER = 9;
  localparam int SW_OFF   = 6;
  localparam int SW_VOV   = 5;
  localparam int SW_IOC   = 4;
  localparam int SW_VINUV = 3;
  localparam int SW_TEMP  = 2;
  localparam int SW_CML   = 1;

  // ==========================================================
  // Detail register slots and shared bit positions
  localparam int DET_VOUT  = 0;
  localparam int DET_IOUT  = 1;
  localparam int DET_INPUT = 2;
  localparam int DET_TEMP  = 3;
  localparam int DET_CML   = 4;
  localparam int DET_MFR   = 5;
  localparam int DET_NUM   = 6;
  localparam int B_OV_FLT  = 7;
  localparam int B_OV_WRN  = 6;
  localparam int B_UV_WRN  = 5;
  localparam int B_UV_FLT  = 4;
  localparam int B_VMAX    = 3;
  localparam int B_OC_WRN  = 5;
  localparam int B_UC_FLT  = 4;
  localparam int B_CML_WR  = 1;
  localparam logic [7:0] CML_EXT_MASK = 8'he0;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int PG_DELAY_MS   = 2;
  localparam int PG_DELAY_CYC  =
    PG_DELAY_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [15:0] VOUT_MIN_MV = 16'h0064;

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic vout_ov_flt;
    logic vout_ov_wrn;
    logic vout_uv_wrn;
    logic vout_uv_flt;
    logic iout_oc_flt;
    logic iout_oc_wrn;
    logic iout_uc_flt;
    logic vin_ov_flt;
    logic vin_ov_wrn;
    logic vin_uv_wrn;
    logic vin_uv_flt;
    logic ot_flt;
    logic ot_wrn;
    logic ut_wrn;
    logic ut_flt;
  } fault_evt_s;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] code;
  } status_cmd_s;

endpackage : fault_status_pkg

// ===== src/fault_status_bank.sv
// Read-only fault status bank: summary byte, summary word, vout status.
// Assumes a command decoder presents one command per valid cycle and
// that fault detectors give one-cycle event pulses.
module fault_status_bank
  import fault_status_pkg::*;
#(
  parameter int PG_CYC = PG_DELAY_CYC,
  parameter int PG_W   = 18
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  input  wire fault_evt_s  i_evt,
  input  wire logic [7:0]  i_cml_evt,
  input  wire logic [7:0]  i_mfr_evt,
  input  wire logic        i_clear_faults,
  input  wire logic        i_enable,
  input  wire logic        i_output_on,
  input  wire logic        i_pgood_raw,
  input  wire logic        i_vset_valid,
  input  wire logic [15:0] i_vset_mv,
  input  wire logic [15:0] i_vout_max_mv,
  input  wire status_cmd_s i_cmd,
  output logic             o_rd_valid,
  output logic             o_rd_hit,
  output logic [15:0]      o_rd_data,
  output logic             o_wr_reject,
  output logic             o_power_good,
  output logic [15:0]      o_summary_word,
  output logic [7:0]       o_vout_status
);

  // ==========================================================
  // Elaboration checks
  if (PG_CYC < 1 || PG_CYC >= (1 << PG_W) - 1) begin : g_chk
    $error("PG_CYC does not fit the power-good counter");
  end

  // ==========================================================
  // Detail status bytes, sticky until cleared
  logic [7:0]  det_ff  [DET_NUM];
  logic [7:0]  nxt_det [DET_NUM];
  logic [7:0]  det_set [DET_NUM];
  logic        cmd_is_status;
  logic        bad_write;
  logic        vset_bad;

  always_comb begin
    cmd_is_status = (i_cmd.code == CMD_SUMMARY_BYTE)
                 || (i_cmd.code == CMD_SUMMARY_WORD)
                 || (i_cmd.code == CMD_VOUT_STATUS);
    bad_write = i_cmd.valid && i_cmd.write && cmd_is_status;
    // Bounds compared in millivolts on both sides
    vset_bad  = i_vset_valid
             && ((i_vset_mv > i_vout_max_mv)
              || (i_vset_mv < VOUT_MIN_MV));
  end

  always_comb begin
    for (int k = 0; k < DET_NUM; k++) begin
      det_set[k] = DETAIL_RESET;
    end
    // Warnings and faults latch independently; a fast fault
    // may arrive with no warning ahead of it.
    det_set[DET_VOUT][B_OV_FLT]  = i_evt.vout_ov_flt;
    det_set[DET_VOUT][B_OV_WRN]  = i_evt.vout_ov_wrn;
    det_set[DET_VOUT][B_UV_WRN]  = i_evt.vout_uv_wrn;
    det_set[DET_VOUT][B_UV_FLT]  = i_evt.vout_uv_flt;
    det_set[DET_VOUT][B_VMAX]    = vset_bad;
    det_set[DET_IOUT][B_OV_FLT]  = i_evt.iout_oc_flt;
    det_set[DET_IOUT][B_OC_WRN]  = i_evt.iout_oc_wrn;
    det_set[DET_IOUT][B_UC_FLT]  = i_evt.iout_uc_flt;
    det_set[DET_INPUT][B_OV_FLT] = i_evt.vin_ov_flt;
    det_set[DET_INPUT][B_OV_WRN] = i_evt.vin_ov_wrn;
    det_set[DET_INPUT][B_UV_WRN] = i_evt.vin_uv_wrn;
    det_set[DET_INPUT][B_UV_FLT] = i_evt.vin_uv_flt;
    det_set[DET_TEMP][B_OV_FLT]  = i_evt.ot_flt;
    det_set[DET_TEMP][B_OV_WRN]  = i_evt.ot_wrn;
    det_set[DET_TEMP][B_UV_WRN]  = i_evt.ut_wrn;
    det_set[DET_TEMP][B_UV_FLT]  = i_evt.ut_flt;
    det_set[DET_CML]             = i_cml_evt & CML_EXT_MASK;
    det_set[DET_CML][B_CML_WR]   = bad_write;
    det_set[DET_MFR]             = i_mfr_evt;
  end

  for (genvar g = 0; g < DET_NUM; g++) begin : g_det
    // Set beats clear so no event is lost in the clear cycle
    always_comb begin
      nxt_det[g] = det_set[g]
                 | (det_ff[g] & {8{~i_clear_faults}});
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        det_ff[g] <= DETAIL_RESET;
      end else begin
        det_ff[g] <= nxt_det[g];
      end
    end
  end

  // ==========================================================
  // Power-good qualification
  logic [PG_W-1:0] pg_cnt_ff;
  logic [PG_W-1:0] nxt_pg_cnt;
  logic            pg_ff;
  logic            nxt_pg;

  always_comb begin
    nxt_pg_cnt = pg_cnt_ff;
    if (!i_enable) begin
      nxt_pg_cnt = '0;
    end else if (pg_cnt_ff < PG_W'(PG_CYC)) begin
      nxt_pg_cnt = pg_cnt_ff + PG_W'(1);
    end
    // Held low for the first 2 ms of enable
    nxt_pg = i_enable && i_output_on && i_pgood_raw
          && (pg_cnt_ff >= PG_W'(PG_CYC));
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pg_cnt_ff <= '0;
      pg_ff     <= 1'b0;
    end else begin
      pg_cnt_ff <= nxt_pg_cnt;
      pg_ff     <= nxt_pg;
    end
  end

  // ==========================================================
  // Summary word, one storage for both summary commands
  logic [15:0] summary_ff;
  logic [15:0] nxt_summary;
  logic        any_detail;

  always_comb begin
    any_detail = 1'b0;
    for (int k = 0; k < DET_NUM; k++) begin
      any_detail = any_detail | (|det_ff[k]);
    end
    // Positions not assigned below stay zero
    nxt_summary           = SUMMARY_RESET;
    nxt_summary[SW_VOUT]  = |det_ff[DET_VOUT];
    nxt_summary[SW_IOUT]  = det_ff[DET_IOUT][B_OV_FLT]
                          | det_ff[DET_IOUT][B_UC_FLT];
    nxt_summary[SW_INPUT] = |det_ff[DET_INPUT];
    nxt_summary[SW_MFR]   = |det_ff[DET_MFR];
    nxt_summary[SW_PGN]   = ~pg_ff;
    nxt_summary[SW_OTHER] = any_detail;
    // Live level: covers never enabled as well as shut down
    nxt_summary[SW_OFF]   = ~i_output_on;
    nxt_summary[SW_VOV]   = det_ff[DET_VOUT][B_OV_FLT];
    nxt_summary[SW_IOC]   = det_ff[DET_IOUT][B_OV_FLT];
    nxt_summary[SW_VINUV] = det_ff[DET_INPUT][B_UV_FLT];
    nxt_summary[SW_TEMP]  = |det_ff[DET_TEMP];
    nxt_summary[SW_CML]   = |det_ff[DET_CML];
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      summary_ff <= SUMMARY_RESET;
    end else begin
      summary_ff <= nxt_summary;
    end
  end

  // ==========================================================
  // Command answer
  logic        rd_valid_ff;
  logic        rd_hit_ff;
  logic [15:0] rd_data_ff;
  logic        wr_reject_ff;
  logic        nxt_rd_valid;
  logic        nxt_rd_hit;
  logic [15:0] nxt_rd_data;
  logic        nxt_wr_reject;

  always_comb begin
    nxt_rd_valid  = i_cmd.valid && !i_cmd.write;
    nxt_rd_hit    = nxt_rd_valid && cmd_is_status;
    nxt_wr_reject = bad_write;
    nxt_rd_data   = 16'h0000;
    if (nxt_rd_valid) begin
      case (i_cmd.code)
        CMD_SUMMARY_BYTE: begin
          nxt_rd_data = {8'h00, summary_ff[7:0]};
        end
        CMD_SUMMARY_WORD: begin
          nxt_rd_data = summary_ff;
        end
        CMD_VOUT_STATUS: begin
          nxt_rd_data = {8'h00, det_ff[DET_VOUT]};
        end
        default: begin
          nxt_rd_data = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_valid_ff  <= 1'b0;
      rd_hit_ff    <= 1'b0;
      rd_data_ff   <= 16'h0000;
      wr_reject_ff <= 1'b0;
    end else begin
      rd_valid_ff  <= nxt_rd_valid;
      rd_hit_ff    <= nxt_rd_hit;
      rd_data_ff   <= nxt_rd_data;
      wr_reject_ff <= nxt_wr_reject;
    end
  end

  // ==========================================================
  // Outputs, all from flip-flops
  always_comb begin
    o_rd_valid     = rd_valid_ff;
    o_rd_hit       = rd_hit_ff;
    o_rd_data      = rd_data_ff;
    o_wr_reject    = wr_reject_ff;
    o_power_good   = pg_ff;
    o_summary_word = summary_ff;
    o_vout_status  = det_ff[DET_VOUT];
  end

endmodule : fault_status_bank

// ===== dv/fault_status_host.sv
// Host model: issues one status command and collects the answer.
// Assumes the bank answers one cycle after it takes a command.
module fault_status_host
  import fault_status_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rd_valid,
  input  wire logic        i_rd_hit,
  input  wire logic [15:0] i_rd_data,
  input  wire logic        i_wr_reject,
  output status_cmd_s      o_cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // Command task
  initial o_cmd = '0;
  // Released code is inverted so a stale code never matches
  task automatic xfer(input logic w, input logic [7:0] c,
                      output logic [15:0] d, output logic ok);
    @(negedge i_ref_clk);
    o_cmd = '{1'b1, w, c};
    @(negedge i_ref_clk);
    o_cmd = '{1'b0, 1'b0, ~c};
    d = i_rd_data;
    ok = w ? i_wr_reject : i_rd_valid & i_rd_hit;
  endtask : xfer
endmodule : fault_status_host

// ===== dv/fault_status_bank_assertions.sv
// Checker of the fault status bank, seen from its ports only.
// Assumes the bind below attaches it to every bank instance.
module fault_status_bank_assertions
  import fault_status_pkg::*;
#(
  parameter int PG_CYC = PG_DELAY_CYC
) (
  input wire logic        i_ref_clk,
  input wire logic        i_resetn,
  input wire fault_evt_s  i_evt,
  input wire logic        i_enable,
  input wire logic        i_output_on,
  input wire logic        i_pgood_raw,
  input wire status_cmd_s i_cmd,
  input wire logic        o_rd_valid,
  input wire logic        o_rd_hit,
  input wire logic [15:0] o_rd_data,
  input wire logic        o_wr_reject,
  input wire logic        o_power_good,
  input wire logic [15:0] o_summary_word,
  input wire logic [7:0]  o_vout_status
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);
  logic        st_hit;
  logic [15:0] rd_exp;
  int          en_cnt_ff;
  // ==========
  // Enabled edges seen, saturating just past the qualification time
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      en_cnt_ff <= 0;
    end else if (!i_enable) begin
      en_cnt_ff <= 0;
    end else if (en_cnt_ff <= PG_CYC) begin
      en_cnt_ff <= en_cnt_ff + 1;
    end
  end
  // ==========
  // Expected answer to the command now on the port
  always_comb begin
    st_hit = i_cmd.code inside {8'h78, 8'h79, 8'h7a};
    case (i_cmd.code)
      8'h78:   rd_exp = {8'h00, o_summary_word[7:0]};
      8'h79:   rd_exp = o_summary_word;
      8'h7a:   rd_exp = {8'h00, o_vout_status};
      default: rd_exp = 16'h0000;
    endcase
  end
  // ==========
  // Properties
  ov_fault_a: assert property (
    i_evt.vout_ov_flt |=> o_vout_status[7] ##1
    (o_summary_word & 16'h8220) == 16'h8220) else $error("ov lost");
  oc_fault_a: assert property (
    i_evt.iout_oc_flt |-> ##2 (o_summary_word & 16'h4210) == 16'h4210)
    else $error("oc lost");
  vin_uv_a: assert property (
    i_evt.vin_uv_flt |-> ##2 (o_summary_word & 16'h2208) == 16'h2208)
    else $error("vin uv lost");
  temp_bit_a: assert property (
    i_evt.ot_wrn || i_evt.ut_flt |-> ##2 o_summary_word[2])
    else $error("temp lost");
  off_bit_a: assert property (
    $stable(i_output_on) [*3] |-> o_summary_word[6] == !i_output_on)
    else $error("off bit wrong");
  pg_bit_a: assert property (
    $stable(o_power_good) [*3] |-> o_summary_word[11] == !o_power_good)
    else $error("pg bit wrong");
  wr_reject_a: assert property (
    i_cmd.valid && i_cmd.write && st_hit |=> o_wr_reject ##1
    o_summary_word[1]) else $error("write not refused");
  read_ans_a: assert property (
    i_cmd.valid && !i_cmd.write |=> o_rd_valid && o_rd_hit ==
    $past(st_hit) && o_rd_data == $past(rd_exp)) else $error("bad read");
  unused_zero_a: assert property (
    (o_summary_word & 16'h0581) == 16'h0000 && o_vout_status[2:0] == 3'h0)
    else $error("unused bit set");
  pg_delay_a: assert property (
    o_power_good |-> en_cnt_ff > PG_CYC) else $error("pg too early");
  pg_qual_a: assert property (
    o_power_good |-> $past(i_output_on) && $past(i_pgood_raw))
    else $error("pg without inputs");
  rd_word_c: cover property (i_cmd.valid && i_cmd.code == 8'h79);
  wr_rej_c: cover property (o_wr_reject);
  pg_up_c: cover property ($rose(o_power_good));
endmodule : fault_status_bank_assertions

bind fault_status_bank fault_status_bank_assertions #(.PG_CYC(PG_CYC))
  status_chk (.*);

// ===== dv/tb_top.sv
// Self-checking bench of the fault status bank with its host model.
// Assumes 100 MHz and a power-good delay cut to 20 cycles.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import fault_status_pkg::*;
  typedef struct packed {
    logic [14:0] evt;
    logic [7:0]  vs;
    logic [15:0] sw;
  } row_s;
  // Event, vout status byte and summary word it must give
  localparam row_s ROWS [15] = '{
    '{15'h4000, 8'h80, 16'h8220}, '{15'h2000, 8'h40, 16'h8200},
    '{15'h1000, 8'h20, 16'h8200}, '{15'h0800, 8'h10, 16'h8200},
    '{15'h0400, 8'h00, 16'h4210}, '{15'h0200, 8'h00, 16'h0200},
    '{15'h0100, 8'h00, 16'h4200}, '{15'h0080, 8'h00, 16'h2200},
    '{15'h0040, 8'h00, 16'h2200}, '{15'h0020, 8'h00, 16'h2200},
    '{15'h0010, 8'h00, 16'h2208}, '{15'h0008, 8'h00, 16'h0204},
    '{15'h0004, 8'h00, 16'h0204}, '{15'h0002, 8'h00, 16'h0204},
    '{15'h0001, 8'h00, 16'h0204}};
  localparam logic [15:0] VSET [4] = '{16'h0063, 16'h0064, 16'h03e9,
                                      16'h03e8};
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  fault_evt_s  evt = '0;
  logic [7:0]  cml = '0;
  logic [7:0]  mfr = '0;
  logic        clr = 1'b0;
  logic        on = 1'b1;
  logic        praw = 1'b1;
  logic        vld = 1'b0;
  logic [15:0] vset = '0;
  status_cmd_s cmd;
  logic        rd_vld, rd_hit, wr_rej, pg, ok;
  logic [15:0] rd_data, sw, d;
  logic [7:0]  vs;
  int          n_errors = 0;
  int          compares = 0;
  always #5 clk = ~clk;
  fault_status_bank #(.PG_CYC(20)) dut (.i_ref_clk(clk), .i_resetn(rstn),
    .i_evt(evt), .i_cml_evt(cml), .i_mfr_evt(mfr), .i_clear_faults(clr),
    .i_enable(on), .i_output_on(on), .i_pgood_raw(praw),
    .i_vset_valid(vld), .i_vset_mv(vset), .i_vout_max_mv(16'h03e8),
    .i_cmd(cmd), .o_rd_valid(rd_vld), .o_rd_hit(rd_hit),
    .o_rd_data(rd_data), .o_wr_reject(wr_rej), .o_power_good(pg),
    .o_summary_word(sw), .o_vout_status(vs));
  fault_status_host host (.i_ref_clk(clk), .i_rd_valid(rd_vld),
    .i_rd_hit(rd_hit), .i_rd_data(rd_data), .i_wr_reject(wr_rej),
    .o_cmd(cmd));
  // ==========
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic clear_all;
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    tick(2);
  endtask : clear_all
  task automatic finish_test;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  // ==========
  // Sequence
  initial begin
    tick(16);
    chk(sw, 16'h0000);
    rstn = 1'b1;
    tick(2);
    chk(16'(sw[11]), 16'h0001);
    // 18 enabled edges so far, short of the qualification time
    tick(16);
    chk(16'(pg), 16'h0000);
    for (int i = 0; i < 100 && pg !== 1'b1; i++) tick(1);
    chk(16'(pg), 16'h0001);
    if (pg !== 1'b1) finish_test();
    tick(3);
    chk(sw, 16'h0000);
    $display("reset done");
    foreach (ROWS[k]) begin
      clear_all();
      evt = ROWS[k].evt;
      tick(1);
      evt = '0;
      tick(2);
      chk({8'h00, vs}, {8'h00, ROWS[k].vs});
      chk(sw, ROWS[k].sw);
      host.xfer(1'b0, 8'h79, d, ok);
      chk(d, ROWS[k].sw);
      chk(16'(ok), 16'h0001);
      host.xfer(1'b0, 8'h78, d, ok);
      chk(d, {8'h00, ROWS[k].sw[7:0]});
      host.xfer(1'b0, 8'h7a, d, ok);
      chk(d, {8'h00, ROWS[k].vs});
    end
    $display("event table done");
    clear_all();
    // Event and clear in one cycle: the event must survive
    clr = 1'b1;
    evt.vout_ov_flt = 1'b1;
    tick(1);
    clr = 1'b0;
    evt = '0;
    tick(1);
    chk({8'h00, vs}, 16'h0080);
    tick(1);
    chk(sw, 16'h8220);
    $display("set beats clear done");
    clear_all();
    cml = 8'h1f;
    tick(1);
    cml = '0;
    tick(2);
    chk(sw, 16'h0000);
    cml = 8'h80;
    mfr = 8'h01;
    tick(1);
    cml = '0;
    mfr = '0;
    tick(2);
    chk(sw, 16'h1202);
    clear_all();
    for (int c = 8'h77; c <= 8'h7b; c++) begin
      host.xfer(1'b1, 8'(c), d, ok);
      chk(16'(ok), 16'(c >= 8'h78 && c <= 8'h7a));
    end
    tick(2);
    chk(sw, 16'h0202);
    host.xfer(1'b0, 8'h7b, d, ok);
    chk(d, 16'h0000);
    chk({14'h0, rd_vld, ok}, 16'h0002);
    $display("commands done");
    foreach (VSET[k]) begin
      clear_all();
      vset = VSET[k];
      vld = 1'b1;
      tick(1);
      vld = 1'b0;
      tick(1);
      chk(16'(vs), {12'h0, VSET[k] > 16'h03e8 || VSET[k] < 16'h0064,
        3'h0});
    end
    $display("setpoint done");
    clear_all();
    praw = 1'b0;
    tick(3);
    chk(16'(pg), 16'h0000);
    chk(sw, 16'h0800);
    praw = 1'b1;
    tick(3);
    chk(16'(pg), 16'h0001);
    chk(sw, 16'h0000);
    $display("power good done");
    clear_all();
    on = 1'b0;
    tick(4);
    chk(sw, 16'h0840);
    $display("output off done");
    // Reset in mid-run with a sticky fault standing
    evt.vout_ov_flt = 1'b1;
    tick(1);
    evt = '0;
    tick(2);
    chk({8'h00, vs}, 16'h0080);
    rstn = 1'b0;
    tick(2);
    chk(sw | {8'h00, vs}, 16'h0000);
    rstn = 1'b1;
    tick(2);
    chk(sw, 16'h0840);
    chk({8'h00, vs}, 16'h0000);
    $display("mid reset done");
    finish_test();
  end
endmodule : tb_top
